/* File: bench/dmsp_far_side_model.sv */
// Far side of the motor PWM: servo controller strobe line and pulled-up motor pin.
// Assumes the bench picks strobe, long high or long low through cmd_req_in.
`timescale 1ns/100ps
module dmsp_far_side_model (
    input  wire logic       ref_clk_in,
    input  wire logic [1:0] cmd_req_in,
    input  wire logic       pin_oe_in,
    input  wire logic       pin_data_in,
    output logic            strobe_line_out,
    output logic            pin_level_out
);
    int unsigned run_left;

    // Pull-up on the open-drain line: a released pin reads high
    assign pin_level_out = pin_oe_in ? pin_data_in : 1'b1;

    initial begin
        strobe_line_out = 1'b0;
        run_left = 1;
    end

    // Word strobes last 1..3 cycles, so they never pass for a command
    always @(negedge ref_clk_in) begin
        if (cmd_req_in == 2'h1)
            strobe_line_out <= 1'b1;
        else if (cmd_req_in == 2'h2)
            strobe_line_out <= 1'b0;
        else if (run_left <= 1) begin
            strobe_line_out <= ~strobe_line_out;
            run_left = 1 + ($urandom % 3);
        end else
            run_left = run_left - 1;
    end
endmodule

/* File: bench/dmsp_motor_pwm_tb_top.sv */
// Self-checking bench for the motor PWM: FIFO-fill duty, start and stop forcing.
// Assumes a shortened hold time and a 4-cycle command run.
`timescale 1ns/100ps
module dmsp_motor_pwm_tb_top;
    import dmsp_pkg::*;
    localparam int unsigned HOLD = 600;
    logic       ref_clk_in;
    logic       rst_in;
    logic       strobe;
    logic       pin_oe;
    logic       pin_data;
    logic       pin_level;
    logic [5:0] wr_addr;
    logic [5:0] rd_addr;
    logic [1:0] mode;
    logic [1:0] mode_seen;
    logic [1:0] cmd_req;
    logic [1:0] exp_q[$];
    int         bad_count = 0;
    int         tests_run = 0;

    dmsp_motor_pwm #(.HOLD_CYCS(HOLD), .CMD_RUN(4)) u_dut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .subcode_strobe_motor_cmd_in(strobe),
        .fifo_write_addr_in(wr_addr), .fifo_read_addr_in(rd_addr),
        .motor_speed_pwm_out(pin_data), .motor_speed_pwm_oe_out(pin_oe),
        .motor_mode_out(mode));

    dmsp_far_side_model u_far (
        .ref_clk_in(ref_clk_in), .cmd_req_in(cmd_req), .pin_oe_in(pin_oe),
        .pin_data_in(pin_data), .strobe_line_out(strobe), .pin_level_out(pin_level));

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    task automatic summarize();
        $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp_mode(input logic [1:0] exp_m, input logic [1:0] got);
        tests_run++;
        if (got !== exp_m) begin
            bad_count++;
            $display("BAD mode expected %0d seen %0d", exp_m, got);
        end
    endtask

    // Any window of one period holds exactly thr released cycles
    task automatic cmp_duty(input int unsigned exp_thr);
        int unsigned highs;
        highs = 0;
        repeat (PERIOD_CYC) begin
            // Mid-cycle sample, clear of the edge that launches the pin
            @(negedge ref_clk_in);
            highs = highs + ((pin_level === 1'b1) ? 1 : 0);
        end
        tests_run++;
        if (highs != exp_thr) begin
            bad_count++;
            $display("BAD duty expected %0d seen %0d", exp_thr, highs);
        end
    endtask

    task automatic command(input logic [1:0] req);
        exp_q.push_back(req);
        @(negedge ref_clk_in) cmd_req <= req;
        repeat (8) @(negedge ref_clk_in);
        cmd_req <= 2'h0;
    endtask

    // Each mode change must match the oldest noted expectation
    always @(negedge ref_clk_in) begin
        if (!rst_in && mode !== mode_seen) begin
            mode_seen = mode;
            if (exp_q.size() == 0)
                cmp_mode(2'hX, mode);
            else
                cmp_mode(exp_q.pop_front(), mode);
        end
    end

    initial begin
        #2_000_000;
        bad_count++;
        summarize();
    end

    initial begin
        int unsigned fill;
        int unsigned rd;
        int unsigned exp_n;
        void'($urandom(50341));
        rst_in = 1'b1;
        cmd_req = 2'h0;
        wr_addr = 6'h00;
        rd_addr = 6'h00;
        mode_seen = 2'h0;
        exp_n = 0;
        repeat (16) @(posedge ref_clk_in);
        @(negedge ref_clk_in) rst_in <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            fill = (i == 0) ? 0 : (i == 1) ? 63 : ($urandom % 64);
            rd = $urandom % 64;
            @(negedge ref_clk_in);
            rd_addr <= 6'(rd);
            wr_addr <= 6'(rd + fill);
            exp_n = ((62 - fill * 61 / 64) * PERIOD_CYC) / DUTY_DEN;
            repeat (2 * PERIOD_CYC) @(posedge ref_clk_in);
            cmp_duty(exp_n);
        end
        command(2'h1);
        repeat (120) @(posedge ref_clk_in);
        cmp_duty(111);
        exp_q.push_back(2'h0);
        repeat (HOLD) @(posedge ref_clk_in);
        cmp_duty(exp_n);
        command(2'h2);
        repeat (120) @(posedge ref_clk_in);
        cmp_duty(1);
        exp_q.push_back(2'h3);
        repeat (HOLD) @(posedge ref_clk_in);
        cmp_duty(56);
        // Stop arriving inside a start hold restarts the hold
        command(2'h1);
        repeat (50) @(posedge ref_clk_in);
        command(2'h2);
        exp_q.push_back(2'h3);
        // Hold end plus 200 cycles, more than one full period, before the half-duty window opens
        repeat (HOLD + 200) @(posedge ref_clk_in);
        cmp_duty(56);
        tests_run++;
        if (exp_q.size() != 0) begin
            bad_count++;
            $display("BAD pending modes expected 0 seen %0d", exp_q.size());
        end
        summarize();
    end
endmodule

/* File: logic/dmsp_motor_pwm.sv */
// Motor speed PWM: duty from FIFO fill, start and stop forcing on the strobe line.
// Assumes ref_clk_in is the crystal-derived system clock; open-drain pin resolved outside.
// Function
// R1 - The motor output is an open-drain PWM signal repeating at 88 kHz.
// R2 - The duty factor takes 62 steps from 1,6% to 98,4%.
// R3 - A start command forces 98,4% duty for 0,2 s, then normal duty resumes.
// R4 - A stop command forces 1,6% duty for 0,2 s, then 50% duty until a new command.
// R5 - Start and stop are signalled on the line shared with the subcode word strobe.
// R6 - The timebase comes from the crystal input or an external slave clock; here only the crystal-derived ref_clk_in, no slave clock input.
// R7 - Normal duty follows the difference between FIFO write and read addresses.
// R8 - All PWM and hold counting runs from the system clock.
// R9 - A fuller FIFO gives lower duty, an emptier one higher, half fill near mid scale.
`timescale 1ns/100ps
module dmsp_motor_pwm
    import dmsp_pkg::*;
#(
    parameter int unsigned ADDR_W    = FILL_SHIFT,
    parameter int unsigned PERIOD    = PERIOD_CYC,
    parameter int unsigned HOLD_CYCS = HOLD_CYC,
    parameter int unsigned CMD_RUN   = CMD_CYC
) (
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    input  wire logic              subcode_strobe_motor_cmd_in,
    input  wire logic [ADDR_W-1:0] fifo_write_addr_in,
    input  wire logic [ADDR_W-1:0] fifo_read_addr_in,
    output logic                   motor_speed_pwm_out,
    output logic                   motor_speed_pwm_oe_out,
    output logic [1:0]             motor_mode_out
);
    initial begin
        if (ADDR_W != FILL_SHIFT) $error("ADDR_W must match fill scaling");
        if (PERIOD < DUTY_DEN || PERIOD >= (1 << PER_W)) $error("PERIOD out of range");
        if (HOLD_CYCS < 2 || HOLD_CYCS >= (1 << HOLD_W)) $error("HOLD_CYCS out of range");
        if (CMD_RUN < 2 || CMD_RUN >= (1 << RUN_W)) $error("CMD_RUN out of range");
    end

    localparam logic [PER_W-1:0]  PER_LAST = PER_W'(PERIOD - 1);
    localparam logic [PER_W-1:0]  THR_MIN  = PER_W'((STEP_MIN * PERIOD) / DUTY_DEN);
    localparam logic [PER_W-1:0]  THR_MAX  = PER_W'((STEP_MAX * PERIOD) / DUTY_DEN);
    localparam logic [PER_W-1:0]  THR_HALF = PER_W'(PERIOD / 2);
    localparam logic [HOLD_W-1:0] HOLD_TOP = HOLD_W'(HOLD_CYCS - 1);

    logic start_hit;
    logic stop_hit;

    // Long high run means start, long low run means stop
    dmsp_run_det #(
        .LEVEL   (1'b1),
        .RUN_CYC (RUN_W'(CMD_RUN))
    ) u_start_det (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .line_in    (subcode_strobe_motor_cmd_in),
        .hit_out    (start_hit)
    ); // [R5]

    dmsp_run_det #(
        .LEVEL   (1'b0),
        .RUN_CYC (RUN_W'(CMD_RUN))
    ) u_stop_det (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .line_in    (subcode_strobe_motor_cmd_in),
        .hit_out    (stop_hit)
    ); // [R5]

    dmsp_state_s         s_r;
    dmsp_state_s         s_nxt;
    logic [ADDR_W-1:0]   fill;
    logic [ADDR_W+5:0]   fill_scaled;
    logic [STEP_W-1:0]   fill_step;
    logic [PER_W+STEP_W-1:0] thr_prod;
    logic [PER_W-1:0]    thr_normal;

    always_comb begin
        fill        = fifo_write_addr_in - fifo_read_addr_in; // [R7]
        // Map 0..63 onto 62..2 steps: emptier FIFO drives the motor harder
        fill_scaled = (ADDR_W + 6)'(fill) * (ADDR_W + 6)'(STEP_MAX - STEP_MIN);
        fill_step   = STEP_W'(STEP_MAX) - STEP_W'(fill_scaled >> FILL_SHIFT); // [R9]
        thr_prod    = (PER_W + STEP_W)'(fill_step) * (PER_W + STEP_W)'(PERIOD);
        thr_normal  = PER_W'(thr_prod / (PER_W + STEP_W)'(DUTY_DEN)); // [R2]
    end

    always_comb begin
        s_nxt = s_r;
        // Hold timers count system clocks only
        if (s_r.hold_cnt != '0) begin
            s_nxt.hold_cnt = s_r.hold_cnt - HOLD_W'(1); // [R8]
        end
        unique case (s_r.mode)
            DMSP_START_HOLD: begin
                if (s_r.hold_cnt == '0) s_nxt.mode = DMSP_NORMAL; // [R3]
            end
            DMSP_STOP_HOLD: begin
                if (s_r.hold_cnt == '0) s_nxt.mode = DMSP_STOPPED; // [R4]
            end
            DMSP_NORMAL, DMSP_STOPPED: begin
            end
        endcase
        // A fresh command restarts the hold whatever the mode
        if (start_hit) begin
            s_nxt.mode     = DMSP_START_HOLD; // [R3]
            s_nxt.hold_cnt = HOLD_TOP;
        end else if (stop_hit) begin
            s_nxt.mode     = DMSP_STOP_HOLD; // [R4]
            s_nxt.hold_cnt = HOLD_TOP;
        end
        if (s_r.per_cnt == PER_LAST) begin
            s_nxt.per_cnt = '0; // [R1]
            // Duty changes only at period start, avoiding runt pulses
            unique case (s_r.mode)
                DMSP_NORMAL:     s_nxt.thr = thr_normal; // [R7]
                DMSP_START_HOLD: s_nxt.thr = THR_MAX; // [R3]
                DMSP_STOP_HOLD:  s_nxt.thr = THR_MIN; // [R4]
                DMSP_STOPPED:    s_nxt.thr = THR_HALF; // [R4]
            endcase
        end else begin
            s_nxt.per_cnt = s_r.per_cnt + PER_W'(1); // [R8]
        end
        // Pin released (high) for thr cycles, pulled low for the rest
        s_nxt.oe = (s_r.per_cnt >= s_r.thr); // [R1]
    end

    // Single crystal-derived timebase; no other clock enters the block
    always_ff @(posedge ref_clk_in or posedge rst_in) begin // [R6]
        if (rst_in) begin
            s_r <= '{mode: DMSP_NORMAL, hold_cnt: '0, per_cnt: '0,
                     thr: PER_W'(PERIOD / 2), oe: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign motor_speed_pwm_out    = 1'b0; // [R1]
    assign motor_speed_pwm_oe_out = s_r.oe;
    assign motor_mode_out         = s_r.mode;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    period_wrap_a: assert property (s_r.per_cnt == PER_LAST |=> s_r.per_cnt == '0) // [R1]
        else $error("PWM period did not wrap at its last count");
    open_drain_a: assert property (motor_speed_pwm_out == 1'b0) // [R1]
        else $error("open-drain data bit not low");
    pin_follow_a: assert property (1'b1 |=> motor_speed_pwm_oe_out ==
                                  ($past(s_r.per_cnt) >= $past(s_r.thr))) // [R1]
        else $error("pin enable does not follow duty compare");
    thr_range_a: assert property (s_r.thr >= THR_MIN && s_r.thr <= THR_MAX) // [R2]
        else $error("duty threshold outside 62-step range");
    start_enter_a: assert property (start_hit |=> s_r.mode == DMSP_START_HOLD &&
                                    s_r.hold_cnt == HOLD_TOP) // [R3]
        else $error("start command did not begin the full-duty hold");
    start_duty_a: assert property (s_r.mode == DMSP_START_HOLD && s_r.per_cnt == PER_LAST
                                   |=> s_r.thr == THR_MAX) // [R3]
        else $error("start hold not at maximum duty");
    start_end_a: assert property (s_r.mode == DMSP_START_HOLD && s_r.hold_cnt == '0 &&
                                  !start_hit && !stop_hit |=> s_r.mode == DMSP_NORMAL) // [R3]
        else $error("start hold did not return to normal duty");
    stop_seq_a: assert property (stop_hit |=> s_r.mode == DMSP_STOP_HOLD) // [R4]
        else $error("stop command did not begin the minimum-duty hold");
    stop_duty_a: assert property (s_r.mode == DMSP_STOP_HOLD && s_r.per_cnt == PER_LAST
                                  |=> s_r.thr == THR_MIN) // [R4]
        else $error("stop hold not at minimum duty");
    stopped_half_a: assert property (s_r.mode == DMSP_STOPPED && s_r.per_cnt == PER_LAST
                                     |=> s_r.thr == THR_HALF) // [R4]
        else $error("stopped motor not at half duty");
    normal_duty_a: assert property (s_r.mode == DMSP_NORMAL && s_r.per_cnt == PER_LAST
                                    |=> s_r.thr == $past(thr_normal)) // [R7]
        else $error("normal duty not taken from FIFO fill");
    hold_count_a: assert property (s_r.hold_cnt != '0 && !start_hit && !stop_hit
                                   |=> s_r.hold_cnt == $past(s_r.hold_cnt) - HOLD_W'(1)) // [R8]
        else $error("hold timer did not count down");

    start_done_c: cover property (s_r.mode == DMSP_START_HOLD ##1 s_r.mode == DMSP_NORMAL);
    stop_done_c: cover property (s_r.mode == DMSP_STOP_HOLD ##1 s_r.mode == DMSP_STOPPED);
    restart_c: cover property (s_r.mode == DMSP_STOPPED && start_hit);
    full_fifo_c: cover property (s_r.mode == DMSP_NORMAL && fill == '1);
endmodule

/* File: logic/dmsp_pkg.sv */
// Constants, modes and state carriers for the disc motor speed PWM.
// Assumes a single 10 MHz system clock and no software-visible registers.
package dmsp_pkg;
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned PWM_HZ      = 88_000;
    localparam int unsigned HOLD_MS     = 200;
    // Longest period that still gives at least 88 kHz: round down
    localparam int unsigned PERIOD_CYC  = CLK_HZ / PWM_HZ;
    localparam int unsigned HOLD_CYC    = HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned DUTY_DEN    = 63;
    localparam int unsigned STEP_MIN    = 1;
    localparam int unsigned STEP_MAX    = 62;
    localparam int unsigned FILL_SHIFT  = 6;
    localparam int unsigned CMD_US      = 10;
    localparam int unsigned CMD_CYC     = CMD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PER_W       = 7;
    localparam int unsigned HOLD_W      = 22;
    localparam int unsigned STEP_W      = 6;
    localparam int unsigned RUN_W       = 8;

    typedef enum logic [1:0] {
        DMSP_NORMAL     = 2'h0,
        DMSP_START_HOLD = 2'h1,
        DMSP_STOP_HOLD  = 2'h2,
        DMSP_STOPPED    = 2'h3
    } dmsp_mode_e;

    typedef struct packed {
        dmsp_mode_e          mode;
        logic [HOLD_W-1:0]   hold_cnt;
        logic [PER_W-1:0]    per_cnt;
        logic [PER_W-1:0]    thr;
        logic                oe;
    } dmsp_state_s;

    typedef struct packed {
        logic [RUN_W-1:0] cnt;
        logic             hit;
    } dmsp_run_s;
endpackage

/* File: logic/dmsp_run_det.sv */
// Detects a run of a chosen level on the shared strobe line.
// Assumes the line is synchronous to the clock; short strobe pulses never qualify.
`timescale 1ns/100ps
module dmsp_run_det
    import dmsp_pkg::*;
#(
    parameter logic             LEVEL   = 1'b1,
    parameter logic [RUN_W-1:0] RUN_CYC = RUN_W'(CMD_CYC)
) (
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    input  wire logic line_in,
    output logic      hit_out
);
    initial begin
        if (RUN_CYC < 2) $error("RUN_CYC too small");
    end

    dmsp_run_s s_r;
    dmsp_run_s s_nxt;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.hit = 1'b0;
        if (line_in != LEVEL) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt != RUN_CYC) begin
            s_nxt.cnt = s_r.cnt + RUN_W'(1);
            // One pulse per run, however long the level stays
            s_nxt.hit = (s_r.cnt == RUN_CYC - RUN_W'(1));
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hit_out = s_r.hit;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    run_pulse_a: assert property (hit_out |=> !hit_out) // [R5]
        else $error("run hit lasted more than one cycle");
    run_cover_c: cover property (hit_out);
endmodule
